// *** pkg/pm_ident_consts.svh ***
`ifndef PM_IDENT_CONSTS_SVH
`define PM_IDENT_CONSTS_SVH
// register byte offsets
`define PM_OFF_IDENT    8'h00
`define PM_OFF_POWER_MGMT_CTRL_STATUS     8'h08
`define PM_OFF_IRQ_STS  8'h0C
`define PM_OFF_IRQ_MASK 8'h10
// power state control/status fields
`define PM_BIT_FLAG     15
`define PM_BIT_GATE     8
`define PM_BIT_SKIP     3
`define PM_PWR_HI       1
`define PM_PWR_LO       0
// interrupt status bits
`define PM_IRQ_EVENT    0
`define PM_IRQ_PWRCHG   1
`define PM_IRQ_CFGRST   2
`define PM_IRQ_W        3
// reset values
`define PM_RST_PWR      2'h0
`define PM_RST_IRQ      3'h0
`define PM_RST_DATA     16'h0000
// stages on the asynchronous bus reset pin
`define PM_SYNC_STAGES  2
`endif

// *** pkg/pm_ident_pkg.sv ***
package pm_ident_pkg;

  // two-bit power level encoding
  typedef enum logic [1:0] {
    RUNNING_STATE         = 2'h0,
    LOW_POWER_STATE_ONE   = 2'h1,
    LOW_POWER_STATE_TWO   = 2'h2,
    DEEPEST_HOT_OFF_STATE = 2'h3
  } pwr_level_t;

  // one register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // whole state of the block
  typedef struct packed {
    logic [1:0]  busRstSync;
    logic        busRstSeen;
    pwr_level_t  pwrLevel;
    logic        pmEventFlag;
    logic        pmEventGate;
    logic        skipResetOnWake;
    logic [2:0]  irqSts;
    logic [2:0]  irqMask;
    logic [15:0] rdData;
    logic        pmEventOutN;
    logic        cfgReset;
    logic        irqOut;
  } pm_state_t;

endpackage

// *** hw/power_mgmt_event_and_chip_ident.sv ***
// What this block does
// - a detected power-management event sets the sticky event flag.
// - with flag and gate both set the active-low event output is driven low.
// - with the gate clear the event output stays high whatever the flag.
// - the flag clears only on power-up reset or a one written to its bit.
// - hardware and software resets leave the event flag untouched.
// - once the flag is clear the event output returns high.
// - the gate is read/write, zero after power-up, kept over soft reset.
// - skip bit set, a deepest-to-running move does no internal reset.
// - skip bit clear, a deepest-to-running move fires an internal reset.
// - a system reset returns the device to running with event context kept.
// - the read-only skip bit is loaded from the serial EEPROM bit.
// - power field 0 is running, 1 and 2 low power, 3 deepest hot-off.
// - the host writes the power field and reads back the current level.
// - the ident register is read-only: family, chip, revision, bit 0 zero.
`timescale 1ns/1ps
`include "pm_ident_consts.svh"

module power_mgmt_event_and_chip_ident #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
  parameter logic [3:0] CHIP_CODE   = 4'h6,  // arbitrary value
  parameter logic [2:0] REV_CODE    = 3'h2,  // arbitrary value
  parameter int         DATA_W      = 16
) (
  input  wire logic                   clk_sys,
  input  wire logic                   srst,
  input  wire pm_ident_pkg::reg_req_t busReq,
  output logic [15:0]                 rdData,
  input  wire logic                   pmEventDet,
  input  wire logic                   busRstPin,
  input  wire logic                   eepromLoad,
  input  wire logic                   eepromSkipBit,
  output logic                        pm_event_out_n,
  output pm_ident_pkg::pwr_level_t    pwrLevel,
  output logic                        cfgReset,
  output logic                        irqOut
);

  // the register map is fixed at sixteen data bits
  if (DATA_W != 16) begin : gDataCheck
    $error("DATA_W must be 16");
  end

  // the bus reset edge logic is written for exactly two sync stages
  if (`PM_SYNC_STAGES != 2) begin : gSyncCheck
    $error("sync stage count must be 2");
  end

  pm_ident_pkg::pm_state_t st_q;
  pm_ident_pkg::pm_state_t st_d;
  logic                    wrPmcs;
  logic                    wrSts;
  logic                    wrMask;
  logic                    wake;
  logic                    softRst;
  logic                    busRstRise;
  logic                    flagClr;
  logic [2:0]              evt;
  logic [15:0]             pmcsView;
  logic [15:0]             identView;

  // ident word never changes, so it is built from the parameters alone
  assign identView = {FAMILY_CODE, CHIP_CODE, REV_CODE, 1'b0};

  // read view of the control word; reserved bits are zero
  always_comb begin
    pmcsView                 = `PM_RST_DATA;
    pmcsView[`PM_BIT_FLAG]   = st_q.pmEventFlag;
    pmcsView[`PM_BIT_GATE]   = st_q.pmEventGate;
    pmcsView[`PM_BIT_SKIP]   = st_q.skipResetOnWake;
    pmcsView[`PM_PWR_HI:`PM_PWR_LO] = st_q.pwrLevel;
  end

  // next-state logic for the whole block
  always_comb begin
    st_d   = st_q;
    wrPmcs = busReq.wr && (busReq.addr == `PM_OFF_POWER_MGMT_CTRL_STATUS);
    wrSts  = busReq.wr && (busReq.addr == `PM_OFF_IRQ_STS);
    wrMask = busReq.wr && (busReq.addr == `PM_OFF_IRQ_MASK);
    flagClr = wrPmcs && busReq.wdata[`PM_BIT_FLAG];

    // pin synchroniser; first stage feeds only the second
    st_d.busRstSync = {st_q.busRstSync[0], busRstPin};
    st_d.busRstSeen = st_q.busRstSync[1];
    busRstRise      = st_q.busRstSync[1] && !st_q.busRstSeen;

    wake = wrPmcs
        && (st_q.pwrLevel == pm_ident_pkg::DEEPEST_HOT_OFF_STATE)
        && (busReq.wdata[`PM_PWR_HI:`PM_PWR_LO] == 2'h0);
    softRst = wake && !st_q.skipResetOnWake;

    if (wrPmcs) begin
      st_d.pwrLevel = pm_ident_pkg::pwr_level_t'(
        busReq.wdata[`PM_PWR_HI:`PM_PWR_LO]);
    end
    if (wrPmcs) begin
      st_d.pmEventGate = busReq.wdata[`PM_BIT_GATE];
    end
    // write one clears the flag, zero leaves it
    if (flagClr) begin
      st_d.pmEventFlag = 1'b0;
    end
    // detection wins over a clear in the same cycle
    if (pmEventDet) begin
      st_d.pmEventFlag = 1'b1;
    end
    // skip bit comes only from the EEPROM loader
    if (eepromLoad) begin
      st_d.skipResetOnWake = eepromSkipBit;
    end

    if (wrMask) begin
      st_d.irqMask = busReq.wdata[`PM_IRQ_W-1:0];
    end

    st_d.cfgReset = softRst || busRstRise;
    if (st_d.cfgReset) begin
      st_d.pwrLevel = pm_ident_pkg::RUNNING_STATE;
      st_d.irqMask  = `PM_RST_IRQ;
    end

    // sticky interrupt status, set beats the one-to-clear
    evt                 = '0;
    evt[`PM_IRQ_EVENT]  = pmEventDet;
    evt[`PM_IRQ_PWRCHG] = wrPmcs && (st_d.pwrLevel != st_q.pwrLevel);
    evt[`PM_IRQ_CFGRST] = st_d.cfgReset;
    if (wrSts) begin
      st_d.irqSts = st_q.irqSts & ~busReq.wdata[`PM_IRQ_W-1:0];
    end
    if (st_d.cfgReset) begin
      st_d.irqSts = `PM_RST_IRQ;
    end
    st_d.irqSts = st_d.irqSts | evt;
    st_d.irqOut = |(st_d.irqSts & st_d.irqMask);

    // output follows flag and gate together
    st_d.pmEventOutN = !(st_d.pmEventFlag && st_d.pmEventGate);

    // read data stand one cycle only; unmapped reads give zero
    st_d.rdData = `PM_RST_DATA;
    if (busReq.rd) begin
      case (busReq.addr)
        // read-only ident, writes have no decode
        `PM_OFF_IDENT:    st_d.rdData = identView;
        `PM_OFF_POWER_MGMT_CTRL_STATUS:     st_d.rdData = pmcsView;
        `PM_OFF_IRQ_STS:  st_d.rdData = {13'h0000, st_q.irqSts};
        `PM_OFF_IRQ_MASK: st_d.rdData = {13'h0000, st_q.irqMask};
        default:          st_d.rdData = `PM_RST_DATA;
      endcase
    end
  end

  // power-up reset clears everything, flag and gate included
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= '{busRstSync:      2'h0,
                busRstSeen:      1'b0,
                pwrLevel:        pm_ident_pkg::RUNNING_STATE,
                pmEventFlag:     1'b0,
                pmEventGate:     1'b0,
                skipResetOnWake: 1'b0,
                irqSts:          `PM_RST_IRQ,
                irqMask:         `PM_RST_IRQ,
                rdData:          `PM_RST_DATA,
                pmEventOutN:     1'b1,
                cfgReset:        1'b0,
                irqOut:          1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign rdData         = st_q.rdData;
  assign pm_event_out_n = st_q.pmEventOutN;
  assign pwrLevel       = st_q.pwrLevel;
  assign cfgReset       = st_q.cfgReset;
  assign irqOut         = st_q.irqOut;

  // checks on the block's own outputs
  // a power-up reset may clear the flag, so edges right after it are excused
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  flag_set_a: assert property (
    pmEventDet |=> pmcsView[`PM_BIT_FLAG])
    else $error("event did not set flag");

  out_assert_a: assert property (
    st_q.pmEventFlag && st_q.pmEventGate |-> !pm_event_out_n)
    else $error("event output not asserted");

  out_gated_a: assert property (
    pmEventDet && !st_q.pmEventGate && !wrPmcs
      |=> pm_event_out_n)
    else $error("event output asserted with gate clear");

  flag_clear_a: assert property (
    $fell(st_q.pmEventFlag) && !$past(srst)
      |-> $past(flagClr) && !$past(pmEventDet))
    else $error("flag cleared without a write");

  flag_hold_a: assert property (
    !flagClr && !pmEventDet
      |=> $stable(st_q.pmEventFlag))
    else $error("flag changed without cause");

  flag_keep_a: assert property (
    cfgReset |-> st_q.pmEventFlag == ($past(st_q.pmEventFlag)
      && !$past(flagClr) || $past(pmEventDet)))
    else $error("reset altered the flag");

  out_release_a: assert property (
    flagClr && !pmEventDet |=> pm_event_out_n ##1 pm_event_out_n
      || st_q.pmEventFlag)
    else $error("event output held after clear");

  out_level_a: assert property (
    1'b1
      |-> pm_event_out_n == !(st_q.pmEventFlag && st_q.pmEventGate))
    else $error("event output out of step with flag and gate");

  gate_keep_a: assert property (
    cfgReset && !$past(wrPmcs) |-> $stable(st_q.pmEventGate))
    else $error("soft reset altered gate");

  gate_write_a: assert property (
    wrPmcs
      |=> st_q.pmEventGate == $past(busReq.wdata[`PM_BIT_GATE]))
    else $error("gate write lost");

  gate_hold_a: assert property (
    !wrPmcs
      |=> $stable(st_q.pmEventGate))
    else $error("gate changed without a write");

  skip_wake_a: assert property (
    wake && st_q.skipResetOnWake && !busRstRise
      |=> !cfgReset && pwrLevel == pm_ident_pkg::RUNNING_STATE)
    else $error("internal reset despite skip bit");

  soft_wake_a: assert property (
    softRst |=> cfgReset && pwrLevel == pm_ident_pkg::RUNNING_STATE
      ##1 !cfgReset || busRstRise)
    else $error("wake did not reset");

  cfg_cause_a: assert property (
    cfgReset
      |-> $past(softRst) || $past(busRstRise))
    else $error("internal reset without a cause");

  cfg_pulse_a: assert property (
    cfgReset
      |=> !cfgReset || $past(busRstRise))
    else $error("internal reset longer than one cycle");

  bus_reset_a: assert property (
    $rose(busRstPin) |-> ##[1:3] cfgReset
      && pwrLevel == pm_ident_pkg::RUNNING_STATE)
    else $error("bus reset did not return to running");

  cfg_running_a: assert property (
    cfgReset
      |-> pwrLevel == pm_ident_pkg::RUNNING_STATE)
    else $error("internal reset left a low power level");

  skip_load_a: assert property (
    eepromLoad |=> st_q.skipResetOnWake == $past(eepromSkipBit))
    else $error("skip bit not loaded");

  skip_hold_a: assert property (
    !eepromLoad
      |=> $stable(st_q.skipResetOnWake))
    else $error("skip bit changed without a load");

  pwr_write_a: assert property (
    wrPmcs && !softRst && !busRstRise |=> pwrLevel
      == $past(busReq.wdata[`PM_PWR_HI:`PM_PWR_LO]))
    else $error("power level not written");

  pwr_hold_a: assert property (
    !wrPmcs && !busRstRise
      |=> $stable(pwrLevel))
    else $error("power level changed without a write");

  power_mgmt_ctrl_status_read_a: assert property (
    busReq.rd && busReq.addr == `PM_OFF_POWER_MGMT_CTRL_STATUS
      |=> rdData == $past(pmcsView))
    else $error("control read wrong");

  ident_read_a: assert property (
    busReq.rd && busReq.addr == `PM_OFF_IDENT |=> rdData
      == {FAMILY_CODE, CHIP_CODE, REV_CODE, 1'b0})
    else $error("ident read wrong");

  ident_write_a: assert property (
    busReq.wr && busReq.addr == `PM_OFF_IDENT && !busRstRise && !pmEventDet && !eepromLoad
      |=> $stable(pmcsView))
    else $error("write to ident altered control");

  rsvd_read_a: assert property (
    busReq.rd && busReq.addr == `PM_OFF_POWER_MGMT_CTRL_STATUS
      |=> rdData[14:9] == 6'h00 && rdData[7:4] == 4'h0 && !rdData[2])
    else $error("reserved bits read nonzero");

  rd_idle_a: assert property (
    !$past(busReq.rd)
      |-> rdData == 16'h0000)
    else $error("read data outside read cycle");

  unmapped_read_a: assert property (
    busReq.rd && busReq.addr != `PM_OFF_IDENT && busReq.addr != `PM_OFF_POWER_MGMT_CTRL_STATUS
      && busReq.addr != `PM_OFF_IRQ_STS && busReq.addr != `PM_OFF_IRQ_MASK |=> rdData == 16'h0000)
    else $error("unmapped read nonzero");

  mask_read_a: assert property (
    busReq.rd && busReq.addr == `PM_OFF_IRQ_MASK
      |=> rdData == {13'h0000, $past(st_q.irqMask)})
    else $error("mask read wrong");

  sts_read_a: assert property (
    busReq.rd && busReq.addr == `PM_OFF_IRQ_STS
      |=> rdData == {13'h0000, $past(st_q.irqSts)})
    else $error("status read wrong");

  irq_level_a: assert property (
    1'b1
      |-> irqOut == |(st_q.irqSts & st_q.irqMask))
    else $error("interrupt output out of step");

  // main scenarios reached
  soft_wake_c: cover property (softRst ##1 cfgReset);
  bus_rst_c:   cover property (busRstRise ##1 cfgReset);
  skip_wake_c: cover property (wake && st_q.skipResetOnWake);
  out_low_c:   cover property ($fell(pm_event_out_n));
  irq_c:       cover property ($rose(irqOut));

endmodule

// *** dv/pm_far_side.sv ***
`timescale 1ns/1ps
// system-side partner: wake monitor, bus reset source and serial EEPROM
module pm_far_side (
  input  wire logic clk_sys,
  output logic      pmEventDet,
  output logic      busRstPin,
  output logic      eepromLoad,
  output logic      eepromSkipBit
);
  // everything quiet at time zero
  initial begin
    pmEventDet    = 1'b0;
    busRstPin     = 1'b0;
    eepromLoad    = 1'b0;
    eepromSkipBit = 1'b0;
  end

  task automatic event_pulse;
    @(posedge clk_sys);
    pmEventDet <= 1'b1;
    @(posedge clk_sys);
    pmEventDet <= 1'b0;
  endtask

  // system reset pulse
  // held four cycles so the two-stage synchroniser cannot miss it
  task automatic bus_reset;
    @(posedge clk_sys);
    busRstPin <= 1'b1;
    repeat (4) @(posedge clk_sys);
    busRstPin <= 1'b0;
  endtask

  // eeprom skip bit load
  // after the strobe the data line flips so a late sample is caught
  task automatic load_skip(input logic v);
    @(posedge clk_sys);
    eepromSkipBit <= v;
    eepromLoad    <= 1'b1;
    @(posedge clk_sys);
    eepromLoad    <= 1'b0;
    eepromSkipBit <= ~v;
  endtask
endmodule

// *** dv/power_mgmt_event_and_chip_ident_bench.sv ***
`timescale 1ns/1ps
module power_mgmt_event_and_chip_ident_bench;
  logic                     clk_sys;
  logic                     srst;
  pm_ident_pkg::reg_req_t   busReq;
  logic [15:0]              rdData;
  logic                     pmEventDet;
  logic                     busRstPin;
  logic                     eepromLoad;
  logic                     eepromSkipBit;
  logic                     pmEventOutN;
  pm_ident_pkg::pwr_level_t pwrLevel;
  logic                     cfgReset;
  logic                     irqOut;
  int                       failures = 0;
  int                       tests_run = 0;
  int                       cfgPulses = 0;
  int                       snap;

  power_mgmt_event_and_chip_ident i_dut (
    .clk_sys(clk_sys), .srst(srst), .busReq(busReq), .rdData(rdData),
    .pmEventDet(pmEventDet), .busRstPin(busRstPin), .eepromLoad(eepromLoad),
    .eepromSkipBit(eepromSkipBit), .pm_event_out_n(pmEventOutN),
    .pwrLevel(pwrLevel), .cfgReset(cfgReset), .irqOut(irqOut));

  pm_far_side i_far (
    .clk_sys(clk_sys), .pmEventDet(pmEventDet), .busRstPin(busRstPin),
    .eepromLoad(eepromLoad), .eepromSkipBit(eepromSkipBit));

  // clock at 20 MHz
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // count internal reset pulses; a pulse only lives one cycle
  always @(posedge clk_sys) begin
    if (cfgReset === 1'b1) cfgPulses++;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    busReq.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    busReq <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    busReq.rd <= 1'b0;
    #1 chk(rdData, exp);
  endtask

  task automatic test_done;
    if (failures == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    test_done();
  end

  // main sequence
  initial begin
    srst   = 1'b1;
    busReq = '0;
    repeat (3) @(posedge clk_sys);
    srst <= 1'b0;
    rdchk(8'h00, 16'h5A64);
    wr(8'h00, 16'hFFFF);
    rdchk(8'h00, 16'h5A64);
    rdchk(8'h08, 16'h0000);
    rdchk(8'h20, 16'h0000);
    i_far.event_pulse();
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, pmEventOutN}, 16'h0001);
    rdchk(8'h08, 16'h8000);
    rdchk(8'h0C, 16'h0001);
    chk({15'h0000, irqOut}, 16'h0000);
    wr(8'h10, 16'h0001);
    repeat (2) @(posedge clk_sys);
    chk({15'h0000, irqOut}, 16'h0001);
    wr(8'h0C, 16'h0001);
    repeat (2) @(posedge clk_sys);
    chk({15'h0000, irqOut}, 16'h0000);
    // gate on, flag written 0, reserved and read-only bits written 1
    wr(8'h08, 16'h7FFC);
    repeat (2) @(posedge clk_sys);
    chk({15'h0000, pmEventOutN}, 16'h0000);
    rdchk(8'h08, 16'h8100);
    wr(8'h08, 16'h8100);
    repeat (2) @(posedge clk_sys);
    chk({15'h0000, pmEventOutN}, 16'h0001);
    rdchk(8'h08, 16'h0100);
    // system reset in a low power state keeps the event context
    wr(8'h08, 16'h0102);
    i_far.event_pulse();
    snap = cfgPulses;
    i_far.bus_reset();
    repeat (10) @(posedge clk_sys);
    rdchk(8'h08, 16'h8100);
    chk({14'h0000, pwrLevel}, 16'h0000);
    chk(16'(cfgPulses - snap), 16'h0001);
    // every power level written and read back
    for (int p = 0; p < 4; p++) begin
      wr(8'h08, {14'h0040, p[1:0]});
      rdchk(8'h08, {14'h2040, p[1:0]});
      chk({14'h0000, pwrLevel}, {14'h0000, p[1:0]});
    end
    snap = cfgPulses;
    wr(8'h08, 16'h0100);
    repeat (3) @(posedge clk_sys);
    chk(16'(cfgPulses - snap), 16'h0001);
    i_far.load_skip(1'b1);
    rdchk(8'h08, 16'h8108);
    wr(8'h08, 16'h0103);
    snap = cfgPulses;
    wr(8'h08, 16'h0100);
    repeat (3) @(posedge clk_sys);
    chk(16'(cfgPulses - snap), 16'h0000);
    // power-up reset clears flag, gate and skip bit
    @(posedge clk_sys);
    srst <= 1'b1;
    @(posedge clk_sys);
    srst <= 1'b0;
    rdchk(8'h08, 16'h0000);
    test_done();
  end
endmodule
